/* rtl/clrb_pkg.sv */
// constants, types and helpers shared by the configuration latch block
package clrb_pkg;

	// ----------------------------------------
	// bus and bank geometry
	// ----------------------------------------
	localparam int unsigned CLRB_NUM_BANKS = 12;
	localparam int unsigned CLRB_BANK_W    = 7;
	localparam int unsigned CLRB_ADDR_W    = 4;
	localparam int unsigned CLRB_DATA_W    = 8;
	localparam int unsigned CLRB_CHAR_W    = 10;
	localparam int unsigned CLRB_NUM_TX    = 2;
	localparam int unsigned CLRB_NUM_RX    = 2;
	localparam int unsigned CLRB_STRIDE    = 3;   // banks per channel

	// ----------------------------------------
	// bank offsets
	// ----------------------------------------
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_0   = 4'h0;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_1   = 4'h1;
	localparam logic [3:0] CLRB_OFF_DYNAMIC_BANK_2  = 4'h2;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_3   = 4'h3;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_4   = 4'h4;
	localparam logic [3:0] CLRB_OFF_DYNAMIC_BANK_5  = 4'h5;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_6   = 4'h6;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_7   = 4'h7;
	localparam logic [3:0] CLRB_OFF_DYNAMIC_BANK_8  = 4'h8;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_9   = 4'h9;
	localparam logic [3:0] CLRB_OFF_STATIC_BANK_10  = 4'hA;
	localparam logic [3:0] CLRB_OFF_DYNAMIC_BANK_11 = 4'hB;
	localparam logic [3:0] CLRB_OFF_TX_BASE         = CLRB_OFF_STATIC_BANK_0;
	localparam logic [3:0] CLRB_OFF_RX_BASE         = CLRB_OFF_STATIC_BANK_6;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned CLRB_F_TX_CLKSEL   = 0;  // static bank, first
	localparam int unsigned CLRB_F_TX_RATE     = 1;  // static bank, first
	localparam int unsigned CLRB_F_TX_PRI_ON   = 0;  // dynamic bank
	localparam int unsigned CLRB_F_TX_SEC_ON   = 1;  // dynamic bank
	localparam int unsigned CLRB_F_TX_BIST_OFF = 2;  // dynamic bank
	localparam int unsigned CLRB_F_RX_RATE     = 0;  // static bank, first
	localparam int unsigned CLRB_F_RX_PWR_ON   = 0;  // dynamic bank
	localparam int unsigned CLRB_F_RC_PRI_ON   = 1;  // dynamic bank
	localparam int unsigned CLRB_F_RC_SEC_ON   = 2;  // dynamic bank
	localparam int unsigned CLRB_F_ST_MODE_LO  = 3;  // dynamic, two bits

	// ----------------------------------------
	// reset values and modes
	// ----------------------------------------
	localparam logic [6:0] CLRB_RST_TX_STATIC_A = 7'h01;
	localparam logic [6:0] CLRB_RST_TX_STATIC_B = 7'h00;
	localparam logic [6:0] CLRB_RST_TX_DYNAMIC  = 7'h04;
	localparam logic [6:0] CLRB_RST_RX_STATIC_A = 7'h01;
	localparam logic [6:0] CLRB_RST_RX_STATIC_B = 7'h00;
	localparam logic [6:0] CLRB_RST_RX_DYNAMIC  = 7'h18;
	localparam logic [1:0] CLRB_ST_MODE_CHECK   = 2'h2;

	// ----------------------------------------
	// checker constants
	// ----------------------------------------
	localparam int unsigned CLRB_LFSR_W      = 9;
	localparam logic [8:0]  CLRB_LFSR_SEED   = 9'h1FF;
	localparam int unsigned CLRB_LFSR_TAP    = 4;
	localparam int unsigned CLRB_LOOP_LEN    = 511;
	localparam logic [4:0]  CLRB_ABORT_LIMIT = 5'h10;
	localparam logic [2:0]  CLRB_STS_IDLE    = 3'h0;
	localparam logic [2:0]  CLRB_STS_MISS    = 3'h1;
	localparam logic [2:0]  CLRB_STS_LOOP_OK = 3'h2;
	localparam logic [2:0]  CLRB_STS_WAIT    = 3'h3;
	localparam logic [2:0]  CLRB_STS_LOOP_ER = 3'h4;
	localparam logic [2:0]  CLRB_STS_START   = 3'h7;

	typedef enum logic [2:0] {
		CLRB_CHK_START = 3'b001,
		CLRB_CHK_WAIT  = 3'b010,
		CLRB_CHK_CMP   = 3'b100
	} clrb_chk_state_t;

	// reset value of a bank from its address
	function automatic logic [6:0] clrb_bank_reset(input logic [3:0] a);
		logic [3:0] pos;
		pos = a % 4'(CLRB_STRIDE);
		if (a < CLRB_OFF_RX_BASE) begin
			clrb_bank_reset = (pos == 4'h0) ? CLRB_RST_TX_STATIC_A :
				(pos == 4'h1) ? CLRB_RST_TX_STATIC_B : CLRB_RST_TX_DYNAMIC;
		end else begin
			clrb_bank_reset = (pos == 4'h0) ? CLRB_RST_RX_STATIC_A :
				(pos == 4'h1) ? CLRB_RST_RX_STATIC_B : CLRB_RST_RX_DYNAMIC;
		end
	endfunction

endpackage

/* rtl/clrb_lfsr.sv */
// nine-bit lfsr producing the 511-character reference sequence
`timescale 1ns/10ps
module clrb_lfsr (
	input  wire logic                            clock_i,
	input  wire logic                            rst_i,
	input  wire logic                            load_i,
	input  wire logic                            step_i,
	output logic [clrb_pkg::CLRB_CHAR_W-1:0]     char_o,
	output logic                                 last_o
);
	import clrb_pkg::*;

	logic [CLRB_LFSR_W-1:0] lfsr_q;
	logic [CLRB_LFSR_W-1:0] lfsr_d;

	// next state, x^9 + x^5 + 1, period 511
	assign lfsr_d = {lfsr_q[CLRB_LFSR_W-2:0],
		lfsr_q[CLRB_LFSR_W-1] ^ lfsr_q[CLRB_LFSR_TAP]};

	// expected character and end of loop flag
	assign char_o = {lfsr_q, lfsr_q[CLRB_LFSR_W-1] ^ lfsr_q[0]};
	assign last_o = (lfsr_d == CLRB_LFSR_SEED);

	// seed reload or advance
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr_q <= CLRB_LFSR_SEED;
		end else if (load_i) begin
			lfsr_q <= CLRB_LFSR_SEED;
		end else if (step_i) begin
			lfsr_q <= lfsr_d;
		end
	end

endmodule // clrb_lfsr

/* rtl/clrb_rx_checker.sv */
// receive pattern checker for one channel
`timescale 1ns/10ps
module clrb_rx_checker (
	input  wire logic                            clock_i,
	input  wire logic                            rst_i,
	input  wire logic                            enable_i,
	input  wire logic                            lock_i,
	input  wire logic [clrb_pkg::CLRB_CHAR_W-1:0] char_i,
	output logic [2:0]                           status_o
);
	import clrb_pkg::*;

	clrb_chk_state_t             state_q;
	logic [CLRB_CHAR_W-1:0]      exp_char;
	logic                        last_char;
	logic                        match;
	logic                        start_char;
	logic [4:0]                  excess_q;
	logic                        loop_err_q;
	logic                        abort;
	logic                        in_cmp;

	assign in_cmp     = (state_q == CLRB_CHK_CMP);
	assign match      = (char_i == exp_char);
	assign start_char = match;
	assign abort      = in_cmp && !match &&
		(excess_q == CLRB_ABORT_LIMIT - 5'h01);

	// reference sequence
	clrb_lfsr u_lfsr (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.load_i  (!in_cmp && !(state_q == CLRB_CHK_WAIT && start_char)
			|| abort),
		.step_i  (in_cmp || (state_q == CLRB_CHK_WAIT && start_char)),
		.char_o  (exp_char),
		.last_o  (last_char)
	);

	// checker state machine
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= CLRB_CHK_START;
		end else if (!lock_i || !enable_i) begin
			state_q <= CLRB_CHK_START;
		end else begin
			case (state_q)
				CLRB_CHK_START: state_q <= CLRB_CHK_WAIT;
				CLRB_CHK_WAIT: begin
					if (start_char) begin
						state_q <= CLRB_CHK_CMP;
					end
				end
				CLRB_CHK_CMP: begin
					if (abort) begin
						state_q <= CLRB_CHK_WAIT;
					end
				end
				default: state_q <= CLRB_CHK_START;
			endcase
		end
	end

	// excess of errors over matches, floored at zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			excess_q <= 5'h00;
		end else if (!in_cmp || abort) begin
			excess_q <= 5'h00;
		end else if (!match) begin
			excess_q <= excess_q + 5'h01;
		end else if (excess_q != 5'h00) begin
			excess_q <= excess_q - 5'h01;
		end
	end

	// error seen somewhere in the current loop
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			loop_err_q <= 1'b0;
		end else if (!in_cmp || last_char) begin
			loop_err_q <= 1'b0;
		end else if (!match) begin
			loop_err_q <= 1'b1;
		end
	end

	// status code per character
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= CLRB_STS_IDLE;
		end else if (!enable_i) begin
			status_o <= CLRB_STS_IDLE;
		end else if (in_cmp && last_char) begin
			status_o <= (loop_err_q || !match) ?
				CLRB_STS_LOOP_ER : CLRB_STS_LOOP_OK;
		end else if (in_cmp) begin
			status_o <= match ? CLRB_STS_IDLE : CLRB_STS_MISS;
		end else if (state_q == CLRB_CHK_WAIT) begin
			status_o <= CLRB_STS_WAIT;
		end else begin
			status_o <= CLRB_STS_START;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_lock_loss_start: assert property (@(posedge clock_i) disable iff (rst_i)
		!lock_i |=> state_q == CLRB_CHK_START)
		else $error("checker not in start state after lock loss");
	a_abort_to_wait: assert property (@(posedge clock_i) disable iff (rst_i)
		abort && lock_i && enable_i |=> state_q == CLRB_CHK_WAIT)
		else $error("abort did not return checker to wait");
	a_loop_code_single: assert property (@(posedge clock_i)
		disable iff (rst_i)
		(status_o == CLRB_STS_LOOP_OK || status_o == CLRB_STS_LOOP_ER)
		|=> !(status_o == CLRB_STS_LOOP_OK
			|| status_o == CLRB_STS_LOOP_ER))
		else $error("loop completion code held longer than one char");
	a_disabled_idle: assert property (@(posedge clock_i) disable iff (rst_i)
		!enable_i [*2] |-> state_q == CLRB_CHK_START
			&& status_o == CLRB_STS_IDLE)
		else $error("checker active while disabled");

endmodule // clrb_rx_checker

/* rtl/clrb_config_latch.sv */
// configuration latch banks, power controls and receive self-test
`timescale 1ns/10ps
module clrb_config_latch (
	input  wire logic                            clock_i,
	input  wire logic                            rst_i,
	// configuration port
	input  wire logic                            config_write_strobe_n_i,
	input  wire logic [clrb_pkg::CLRB_ADDR_W-1:0] config_addr_i,
	input  wire logic [clrb_pkg::CLRB_DATA_W-1:0] config_data_i,
	// receive side
	input  wire logic [1:0]                      rx_pll_lock_i,
	input  wire logic [clrb_pkg::CLRB_CHAR_W-1:0] rx_char_0_i,
	input  wire logic [clrb_pkg::CLRB_CHAR_W-1:0] rx_char_1_i,
	output logic [clrb_pkg::CLRB_CHAR_W-1:0]     rx_parallel_out_0_o,
	output logic [clrb_pkg::CLRB_CHAR_W-1:0]     rx_parallel_out_1_o,
	output logic [1:0]                           selftest_status_bit_o,
	output logic [1:0]                           rx_channel_power_on_o,
	output logic [1:0]                           rx_rate_half_o,
	// reclock side
	output logic [1:0]                           primary_reclock_driver_on_o,
	output logic [1:0]                           secondary_reclock_driver_on_o,
	output logic [1:0]                           reclock_logic_on_o,
	// transmit side
	output logic [1:0]                           primary_tx_driver_on_o,
	output logic [1:0]                           secondary_tx_driver_on_o,
	output logic [1:0]                           tx_logic_on_o,
	output logic [1:0]                           tx_input_clock_select_o,
	output logic [1:0]                           tx_phase_align_bypass_o,
	output logic [1:0]                           tx_rate_double_o,
	output logic [1:0]                           tx_selftest_off_o
);
	import clrb_pkg::*;

	// ----------------------------------------
	// bank storage
	// ----------------------------------------
	logic [CLRB_BANK_W-1:0] bank_q [CLRB_NUM_BANKS];
	logic                   wr_hit;

	// address of a channel's bank, used by tx and rx decode
	function automatic logic [3:0] bank_addr(input logic [3:0] base,
		input int unsigned ch, input int unsigned pos);
		bank_addr = base + 4'(ch * CLRB_STRIDE + pos);
	endfunction

	// a write lands only on a mapped bank
	assign wr_hit = !config_write_strobe_n_i &&
		(config_addr_i <= CLRB_OFF_DYNAMIC_BANK_11);

	// latch write while strobe is low; upper data bit has no latch
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < CLRB_NUM_BANKS; i++) begin
				bank_q[i] <= clrb_bank_reset(4'(i));
			end
		end else if (wr_hit) begin
			bank_q[config_addr_i] <= config_data_i[CLRB_BANK_W-1:0];
		end
	end

	// ----------------------------------------
	// transmit channel decode
	// ----------------------------------------
	generate
		for (genvar t = 0; t < CLRB_NUM_TX; t++) begin : g_tx
			logic [CLRB_BANK_W-1:0] stat_a;
			logic [CLRB_BANK_W-1:0] dyn;
			assign stat_a = bank_q[bank_addr(CLRB_OFF_TX_BASE, t, 0)];
			assign dyn    = bank_q[bank_addr(CLRB_OFF_TX_BASE, t, 2)];

			// drivers follow their own enable latches
			assign primary_tx_driver_on_o[t]   = dyn[CLRB_F_TX_PRI_ON];
			assign secondary_tx_driver_on_o[t] = dyn[CLRB_F_TX_SEC_ON];
			// channel logic sleeps when both drivers are off
			assign tx_logic_on_o[t] = dyn[CLRB_F_TX_PRI_ON]
				| dyn[CLRB_F_TX_SEC_ON];
			// 1 selects reference clock and skips phase buffer
			assign tx_input_clock_select_o[t] = stat_a[CLRB_F_TX_CLKSEL];
			assign tx_phase_align_bypass_o[t] = stat_a[CLRB_F_TX_CLKSEL];
			assign tx_rate_double_o[t]  = stat_a[CLRB_F_TX_RATE];
			assign tx_selftest_off_o[t] = dyn[CLRB_F_TX_BIST_OFF];
		end
	endgenerate

	// ----------------------------------------
	// receive channel decode and checkers
	// ----------------------------------------
	logic [CLRB_CHAR_W-1:0] rx_char    [CLRB_NUM_RX];
	logic [CLRB_CHAR_W-1:0] rx_out_q   [CLRB_NUM_RX];
	logic [1:0]             st_mode    [CLRB_NUM_RX];
	logic [2:0]             chk_status [CLRB_NUM_RX];
	logic [CLRB_NUM_RX-1:0] chk_on;
	logic [CLRB_NUM_RX-1:0] sts_bit_q;

	assign rx_char[0] = rx_char_0_i;
	assign rx_char[1] = rx_char_1_i;

	generate
		for (genvar r = 0; r < CLRB_NUM_RX; r++) begin : g_rx
			logic [CLRB_BANK_W-1:0] stat_a;
			logic [CLRB_BANK_W-1:0] dyn;
			logic                   lock_eff;
			assign stat_a = bank_q[bank_addr(CLRB_OFF_RX_BASE, r, 0)];
			assign dyn    = bank_q[bank_addr(CLRB_OFF_RX_BASE, r, 2)];

			// power latch 0 turns pll and analog off
			assign rx_channel_power_on_o[r] = dyn[CLRB_F_RX_PWR_ON];
			assign rx_rate_half_o[r]        = stat_a[CLRB_F_RX_RATE];

			// reclock drivers and reclock function
			assign primary_reclock_driver_on_o[r]   = dyn[CLRB_F_RC_PRI_ON];
			assign secondary_reclock_driver_on_o[r] = dyn[CLRB_F_RC_SEC_ON];
			assign reclock_logic_on_o[r] = dyn[CLRB_F_RC_PRI_ON]
				| dyn[CLRB_F_RC_SEC_ON];

			// self-test mode and its enable
			assign st_mode[r] = dyn[CLRB_F_ST_MODE_LO +: 2];
			assign chk_on[r]  = (st_mode[r] == CLRB_ST_MODE_CHECK);

			// an unpowered pll can never report lock
			assign lock_eff = rx_pll_lock_i[r] & dyn[CLRB_F_RX_PWR_ON];

			clrb_rx_checker u_chk (
				.clock_i  (clock_i),
				.rst_i    (rst_i),
				.enable_i (chk_on[r]),
				.lock_i   (lock_eff),
				.char_i   (rx_char[r]),
				.status_o (chk_status[r])
			);

			// output register, untouched by the reclock controls
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					rx_out_q[r] <= '0;
				end else begin
					rx_out_q[r] <= rx_char[r];
				end
			end

			// status bit follows checker only in check mode
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					sts_bit_q[r] <= 1'b0;
				end else begin
					sts_bit_q[r] <= chk_on[r];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// output bus merge
	// ----------------------------------------
	// in check mode low two bits carry checker status, bit order reversed
	always_comb begin
		rx_parallel_out_0_o = rx_out_q[0];
		rx_parallel_out_1_o = rx_out_q[1];
		selftest_status_bit_o = 2'h0;
		if (sts_bit_q[0]) begin
			rx_parallel_out_0_o[1:0] = {chk_status[0][0],
				chk_status[0][1]};
			selftest_status_bit_o[0] = chk_status[0][2];
		end
		if (sts_bit_q[1]) begin
			rx_parallel_out_1_o[1:0] = {chk_status[1][0],
				chk_status[1][1]};
			selftest_status_bit_o[1] = chk_status[1][2];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [CLRB_NUM_BANKS*CLRB_BANK_W-1:0] bank_flat;
	always_comb begin
		for (int i = 0; i < CLRB_NUM_BANKS; i++) begin
			bank_flat[i*CLRB_BANK_W +: CLRB_BANK_W] = bank_q[i];
		end
	end

	a_write_lands: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_hit |=> bank_q[$past(config_addr_i)]
			== $past(config_data_i[CLRB_BANK_W-1:0]))
		else $error("write did not land in addressed bank");
	a_unmapped_ignored: assert property (@(posedge clock_i)
		disable iff (rst_i)
		(config_write_strobe_n_i || config_addr_i > CLRB_OFF_DYNAMIC_BANK_11)
		|=> $stable(bank_flat))
		else $error("banks changed without a mapped write");
	a_tx_drivers_follow: assert property (@(posedge clock_i)
		disable iff (rst_i)
		wr_hit && config_addr_i == CLRB_OFF_DYNAMIC_BANK_2
		|=> primary_tx_driver_on_o[0] == $past(config_data_i[CLRB_F_TX_PRI_ON])
			&& tx_logic_on_o[0] == |$past(config_data_i[1:0]))
		else $error("transmit driver enable did not follow write");
	a_reclock_stop: assert property (@(posedge clock_i) disable iff (rst_i)
		!primary_reclock_driver_on_o[0] && !secondary_reclock_driver_on_o[0]
		|-> !reclock_logic_on_o[0]
			##1 rx_out_q[0] == $past(rx_char_0_i))
		else $error("reclock off did not stop only the reclock path");
	a_power_latch: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_hit && config_addr_i == CLRB_OFF_DYNAMIC_BANK_8
		&& !config_data_i[CLRB_F_RX_PWR_ON] |=> !rx_channel_power_on_o[0])
		else $error("receive power latch write ignored");
	a_status_gated: assert property (@(posedge clock_i) disable iff (rst_i)
		st_mode[1] != CLRB_ST_MODE_CHECK |=> !selftest_status_bit_o[1]
			&& rx_parallel_out_1_o == $past(rx_char_1_i))
		else $error("status bit on bus outside check mode");
	a_reset_defaults: assert property (@(posedge clock_i)
		$fell(rst_i) |-> !chk_on[0] && !chk_on[1]
			&& !primary_tx_driver_on_o[0] && !secondary_reclock_driver_on_o[1]
			&& tx_input_clock_select_o == 2'h3)
		else $error("latch defaults wrong after reset");

endmodule // clrb_config_latch

/* sim/clrb_host_model.sv */
// host controller model writing the configuration latch banks
`timescale 1ns/10ps
module clrb_host_model (
	input  wire logic       clock_i,
	output logic            strobe_n_o,
	output logic [3:0]      addr_o,
	output logic [7:0]      data_o
);
	// idle bus at time zero
	initial begin
		strobe_n_o = 1'b1;
		addr_o     = 4'hF;
		data_o     = 8'h00;
	end
	// one write, strobe low across exactly one rising edge
	// callers pass fixed bits at their fixed values
	task automatic write_bank(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock_i);
		strobe_n_o = 1'b0;
		addr_o     = a;
		data_o     = d;
		@(negedge clock_i);
		strobe_n_o = 1'b1;
		addr_o     = ~a; // released lines no longer hold the value
		data_o     = ~d;
	endtask
endmodule // clrb_host_model

/* sim/test_clrb_config_latch.sv */
// self-checking bench for the configuration latch block
`timescale 1ns/10ps
module test_clrb_config_latch;
	import clrb_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_i   = 1'b1;
	logic [1:0]  lock    = 2'h3;
	logic [9:0]  ch0     = 10'h000;
	logic [9:0]  ch1     = 10'h000;
	logic        wr_n;
	logic [3:0]  addr;
	logic [7:0]  data;
	logic [9:0]  out0, out1;
	logic [1:0]  sts, pwr, half, rpri, rsec, rlog;
	logic [1:0]  tpri, tsec, tlog, csel, byp, dbl, toff;
	logic [8:0]  st;
	logic [2:0]  code;
	int          fail_count, checks, n_loop, n_bad;

	// 50 MHz clock
	always #10 clock_i = ~clock_i;

	clrb_host_model i_clrb_host_model (.clock_i(clock_i),
		.strobe_n_o(wr_n), .addr_o(addr), .data_o(data));
	clrb_config_latch i_clrb_config_latch (.clock_i(clock_i), .rst_i(rst_i),
		.config_write_strobe_n_i(wr_n), .config_addr_i(addr),
		.config_data_i(data), .rx_pll_lock_i(lock), .rx_char_0_i(ch0),
		.rx_char_1_i(ch1), .rx_parallel_out_0_o(out0),
		.rx_parallel_out_1_o(out1), .selftest_status_bit_o(sts),
		.rx_channel_power_on_o(pwr), .rx_rate_half_o(half),
		.primary_reclock_driver_on_o(rpri),
		.secondary_reclock_driver_on_o(rsec), .reclock_logic_on_o(rlog),
		.primary_tx_driver_on_o(tpri), .secondary_tx_driver_on_o(tsec),
		.tx_logic_on_o(tlog), .tx_input_clock_select_o(csel),
		.tx_phase_align_bypass_o(byp), .tx_rate_double_o(dbl),
		.tx_selftest_off_o(toff));

	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [19:0] seen,
		input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_clrb_host_model.write_bank(a, d);
	endtask

	// bench's own reference character from its lfsr state
	function automatic logic [9:0] ref_char(input logic [8:0] s);
		return {s, s[8] ^ s[0]};
	endfunction

	// drive n characters, sequence or junk, tallying status codes
	task automatic feed(input int n, input bit seq);
		repeat (n) begin
			@(negedge clock_i);
			code = {sts[0], out0[0], out0[1]};
			if (code == 3'h2) n_loop++;
			if (code == 3'h1 || code == 3'h4) n_bad++;
			ch0 = seq ? ref_char(st) : 10'h000;
			ch1 = ~ch1;
			if (seq) st = {st[7:0], st[8] ^ st[4]};
		end
	endtask

	// reset leaves drivers, power and self-test off
	task automatic t_reset();
		check("drv", {tpri,tsec,tlog,rpri,rsec,rlog}, 20'h0);
		check("pwr", {pwr, sts}, 20'h0);
		check("stat", {csel,byp,half,toff,dbl}, 20'h3FC);
		check("outs", {out0, out1}, 20'h0);
	endtask

	// dynamic banks, bit 7 dropped, addresses above 11 ignored
	task automatic t_dyn();
		wr(4'h2, 8'h81);
		wr(4'h5, 8'h02);
		wr(4'h8, 8'h04);
		wr(4'hB, 8'h1B);
		wr(4'hC, 8'h7F);
		check("tx", {tpri,tsec,tlog,toff}, 20'h6C);
		check("rx", {rpri,rsec,rlog,pwr}, 20'h9E);
		check("alias", {csel,byp,half}, 20'h3F);
		wr(4'h8, 8'h18);
		ch0 = 10'h2A5;
		ch1 = 10'h15A;
		@(negedge clock_i);
		check("rc off", {rlog, pwr}, 20'hA);
		check("pass", {out0, out1}, 20'hA955A);
	endtask

	// static banks of the first channels
	task automatic t_static();
		wr(4'h0, 8'h02);
		wr(4'h6, 8'h00);
		check("static", {csel,byp,half,dbl}, 20'hA9);
	endtask

	// check mode: wait, clean loops, abort, lock loss, power off
	task automatic t_bist();
		wr(4'h8, 8'h11);
		feed(6, 1'b0);
		check("wait", code, 20'h3);
		st = 9'h1FF;
		n_loop = 0;
		n_bad = 0;
		feed(1100, 1'b1);
		check("loops", n_loop, 20'h2);
		check("clean", n_bad, 20'h0);
		feed(20, 1'b0);
		check("errs", n_bad, 20'h10);
		check("abort", code, 20'h3);
		st = 9'h1FF;
		feed(20, 1'b1);
		check("resync", code, 20'h0);
		lock[0] = 1'b0;
		feed(1, 1'b1);
		lock[0] = 1'b1;
		feed(4, 1'b1);
		check("unlock", code, 20'h3);
		wr(4'h8, 8'h10);
		feed(3, 1'b1);
		check("pwr off", {pwr[0], code}, 20'h7);
		wr(4'h8, 8'h19);
		@(negedge clock_i);
		check("st off", sts, 20'h0);
	endtask

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clock_i); // whole device held in reset
		@(negedge clock_i);
		rst_i = 1'b0;
		t_reset();
		t_dyn();
		t_static();
		t_bist();
		close_out();
	end

	// watchdog against a hang
	initial begin
		repeat (5000) @(posedge clock_i);
		fail_count++;
		close_out();
	end
endmodule // test_clrb_config_latch
